// ---- rtl/swt_cond_eval.v ----
// Condition field evaluator against the current flags.
// Assumes flags arrive in N,Z,C,V order from the current status word.
module swt_cond_eval (
  // Inputs
  input  wire [3:0] condField,
  input  wire [3:0] flagsNzcv,
  // Result
  output reg        condPass
);
  wire n = flagsNzcv[3];
  wire z = flagsNzcv[2];
  wire c = flagsNzcv[1];
  wire v = flagsNzcv[0];

  always @* begin
    case (condField)
      4'h0: condPass = z;
      4'h1: condPass = ~z;
      4'h2: condPass = c;
      4'h3: condPass = ~c;
      4'h4: condPass = n;
      4'h5: condPass = ~n;
      4'h6: condPass = v;
      4'h7: condPass = ~v;
      4'h8: condPass = c & ~z;
      4'h9: condPass = ~c | z;
      4'hA: condPass = (n == v);
      4'hB: condPass = (n != v);
      4'hC: condPass = ~z & (n == v);
      4'hD: condPass = z | (n != v);
      4'hE: condPass = 1'b1;
      default: condPass = 1'b0;
    endcase
  end
endmodule

// ---- rtl/swt_exec_ctrl.v ----
// Execute-stage control for data processing writes to the program counter and
// for status word transfers between general registers and the status registers.
// Assumes an upstream decoder presents one instruction per issue pulse together
// with its ALU result, ALU flags and the source register value, all on clock.
// Summary of operation
// [RL1] Non-PC destination may update condition flags from ALU flag outputs.
// [RL2] PC destination without flag-set writes PC, status word unchanged.
// [RL3] PC destination with flag-set writes PC and restores saved word atomically.
// [RL4] User code must not write PC with flag-set set.
// [RL5] PC operand reads instruction address plus 8, or plus 12 with register shift.
// [RL6] Test, test-equivalence, compare, compare-negative never write a destination.
// [RL7] Legacy restore form copies saved word when privileged, nothing in user mode.
// [RL8] Cycles: 1 fetch, +1 internal for register shift, 3 fetches on PC write.
// [RL9] Status transfers decode from compare-class opcodes with flag-set clear.
// [RL10] Status read copies current or saved word; write copies register into one.
// [RL11] Flags-only write moves operand top four bits, control bits unchanged.
// [RL12] User mode writes change flags only; privileged writes whole current word.
// [RL13] Saved word chosen by mode at execution; one per privileged mode.
// [RL14] Software must not touch a saved word from user mode.
// [RL15] Only eleven status bits exist; all others reserved.
// [RL16] Software preserves reserved bits with read-modify-write.
// [RL17] Flags-only operand bits 31..28 map to N, Z, C, V.
// [RL18] Status transfers take exactly one fetch, no internal cycles.
// [RL19] Status transfer executes only when its condition passes.
// [RL20] Opcodes 1000..1011 are test, test-equivalence, compare, compare-negative.
// [RL21] Interrupt disables at bits 7 and 6, mode at bits 4 to 0.
`include "swt_regs.vh"

module swt_exec_ctrl (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Instruction issue
  input  wire        issueValid,
  input  wire [3:0]  condField,
  input  wire [3:0]  opcode,
  input  wire        setFlags,
  input  wire        destIsPc,
  input  wire        regShift,
  input  wire        legacyRestore,
  input  wire        xferIsWrite,
  input  wire        xferSaved,
  input  wire        xferFlagsOnly,
  input  wire        xferImmediate,
  // Operands and ALU results
  input  wire [31:0] instrAddr,
  input  wire [31:0] xferOperand,
  input  wire [31:0] aluResult,
  input  wire [3:0]  aluFlags,
  // Results
  output reg  [31:0] pcOperand_q,
  output reg         pcWrite_q,
  output reg  [31:0] pcValue_q,
  output reg         regWrite_q,
  output reg  [31:0] regWriteData_q,
  output reg  [31:0] currentStatus_q,
  output reg  [31:0] savedStatus_q,
  output reg         busy_q,
  output reg  [1:0]  fetchCount_q,
  output reg         internalCycle_q,
  output reg         userPcRestore_q
);

  // Saved words: fast irq, irq, supervisor, abort, undefined.
  localparam SLOT_NONE = 3'h7;
  reg [31:0] savedBank_q [0:4];

  // Maps a mode to its saved status slot; user and unknown modes have none.
  function [2:0] slotOf;
    input [4:0] mode;
    begin
      case (mode)
        `SWT_MODE_FIQ: slotOf = 3'h0;
        `SWT_MODE_IRQ: slotOf = 3'h1;
        `SWT_MODE_SVC: slotOf = 3'h2;
        `SWT_MODE_ABT: slotOf = 3'h3;
        `SWT_MODE_UND: slotOf = 3'h4;
        default:       slotOf = SLOT_NONE;
      endcase
    end
  endfunction

  // Sequencer states.
  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] cyclesLeft_q;
  reg [2:0] cyclesLeft_d;

  wire [4:0]  curMode  = currentStatus_q[`SWT_MODE_HI:`SWT_MODE_LO];
  wire        isUser   = (curMode == `SWT_MODE_USR);
  wire [2:0]  curSlot  = slotOf(curMode);
  wire        hasSaved = (curSlot != SLOT_NONE);
  wire [31:0] savedNow = hasSaved ? savedBank_q[curSlot] : 32'h0000_0000; // [RL13]

  wire condOk;
  swt_cond_eval uCond (
    .condField (condField),
    .flagsNzcv (currentStatus_q[`SWT_FLAG_N:`SWT_FLAG_V]),
    .condPass  (condOk)
  );

  wire isCmpClass = (opcode == `SWT_OP_TEST) | (opcode == `SWT_OP_TEQV) |
                    (opcode == `SWT_OP_CMP)  | (opcode == `SWT_OP_CMPN); // [RL20]
  wire isXfer     = isCmpClass & ~setFlags; // [RL9]
  wire accept     = issueValid & (state_q == ST_IDLE);
  wire exec       = accept & condOk; // [RL19]

  // Status word writes computed for this cycle.
  reg [31:0] curNext;
  reg [31:0] savNext;
  reg        savWe;
  reg        pcWe;
  reg        rWe;
  reg [31:0] rData;
  reg [1:0]  fetches;
  reg        intCyc;
  reg        userRestore;
  reg [31:0] xferMask;

  always @* begin
    curNext     = currentStatus_q;
    savNext     = savedNow;
    savWe       = 1'b0;
    pcWe        = 1'b0;
    rWe         = 1'b0;
    rData       = 32'h0000_0000;
    fetches     = `SWT_FETCH_NORM;
    intCyc      = 1'b0;
    userRestore = 1'b0;
    xferMask    = 32'h0000_0000;
    if (exec) begin
      if (isXfer) begin
        fetches = `SWT_FETCH_XFER; // [RL18]
        if (!xferIsWrite) begin
          rWe   = 1'b1; // [RL10]
          rData = xferSaved ? savedNow : currentStatus_q;
        end else begin
          // Flag writes and user-mode writes touch only bits 31..28.
          if (xferFlagsOnly || xferImmediate || (isUser && !xferSaved)) begin
            xferMask = `SWT_FLAG_MASK; // [RL11] [RL12] [RL17]
          end else begin
            xferMask = `SWT_IMPL_MASK; // [RL12] [RL15]
          end
          if (xferSaved) begin
            savWe   = hasSaved; // [RL10] [RL13]
            savNext = (savedNow & ~xferMask) | (xferOperand & xferMask);
          end else begin
            curNext = (currentStatus_q & ~xferMask) | (xferOperand & xferMask);
          end
        end
      end else if (legacyRestore) begin
        if (!isUser && hasSaved) begin
          curNext = savedNow & `SWT_IMPL_MASK; // [RL7]
        end
      end else begin
        intCyc = regShift; // [RL8]
        if (destIsPc && !isCmpClass) begin
          pcWe    = 1'b1; // [RL2]
          fetches = `SWT_FETCH_PCW; // [RL8]
          if (setFlags) begin
            userRestore = isUser; // [RL4]
            if (hasSaved) begin
              curNext = savedNow & `SWT_IMPL_MASK; // [RL3]
            end
          end
        end else begin
          rWe   = ~isCmpClass; // [RL6]
          rData = aluResult;
          if (setFlags) begin
            curNext[`SWT_FLAG_N:`SWT_FLAG_V] = aluFlags; // [RL1]
          end
        end
      end
    end
  end

  // Multi-cycle instructions hold off the next issue until done.
  always @* begin
    state_d      = state_q;
    cyclesLeft_d = cyclesLeft_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          cyclesLeft_d = {1'b0, fetches} + {2'b00, intCyc} - 3'h1; // [RL8]
          if (cyclesLeft_d != 3'h0) begin
            state_d = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        cyclesLeft_d = cyclesLeft_q - 3'h1;
        if (cyclesLeft_q == 3'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d      = ST_IDLE;
        cyclesLeft_d = 3'h0;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gBank
      always @(posedge clock) begin
        if (!rstn) begin
          savedBank_q[gi] <= `SWT_RESET_WORD;
        end else if (savWe && curSlot == gi) begin
          savedBank_q[gi] <= savNext & `SWT_IMPL_MASK; // [RL15] [RL21]
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (!rstn) begin
      state_q         <= ST_IDLE;
      cyclesLeft_q    <= 3'h0;
      currentStatus_q <= `SWT_RESET_WORD;
      savedStatus_q   <= 32'h0000_0000;
      pcOperand_q     <= 32'h0000_0000;
      pcWrite_q       <= 1'b0;
      pcValue_q       <= 32'h0000_0000;
      regWrite_q      <= 1'b0;
      regWriteData_q  <= 32'h0000_0000;
      busy_q          <= 1'b0;
      fetchCount_q    <= 2'h0;
      internalCycle_q <= 1'b0;
      userPcRestore_q <= 1'b0;
    end else begin
      state_q         <= state_d;
      cyclesLeft_q    <= cyclesLeft_d;
      currentStatus_q <= curNext & `SWT_IMPL_MASK; // [RL15] [RL21]
      savedStatus_q   <= savedNow;
      // Prefetch puts the visible program counter two or three words ahead.
      pcOperand_q     <= instrAddr + (regShift ? `SWT_PC_OFS_REG : `SWT_PC_OFS_IMM); // [RL5]
      pcWrite_q       <= pcWe;
      pcValue_q       <= aluResult;
      regWrite_q      <= rWe;
      regWriteData_q  <= rData;
      busy_q          <= (state_d == ST_BUSY);
      fetchCount_q    <= accept ? fetches : 2'h0;
      internalCycle_q <= accept & intCyc;
      userPcRestore_q <= userRestore;
    end
  end

endmodule

// ---- rtl/swt_regs.vh ----
// Constants for the status word transfer and program counter write control block.
// Assumes the includer is a Verilog-2005 design file or a SystemVerilog sim file, clocked at 250 MHz.
`ifndef SWT_REGS_VH
`define SWT_REGS_VH

// Status word field positions.
`define SWT_FLAG_N      31
`define SWT_FLAG_Z      30
`define SWT_FLAG_C      29
`define SWT_FLAG_V      28
`define SWT_IRQ_DIS     7
`define SWT_FIQ_DIS     6
`define SWT_MODE_HI     4
`define SWT_MODE_LO     0

// Bits that hold state; all others are reserved and read as zero.
`define SWT_IMPL_MASK   32'hF000_00DF
`define SWT_FLAG_MASK   32'hF000_0000
`define SWT_RESET_WORD  32'h0000_00D3

// Processor mode encodings.
`define SWT_MODE_USR    5'h10
`define SWT_MODE_FIQ    5'h11
`define SWT_MODE_IRQ    5'h12
`define SWT_MODE_SVC    5'h13
`define SWT_MODE_ABT    5'h17
`define SWT_MODE_UND    5'h1B

// Compare-class opcodes.
`define SWT_OP_TEST     4'h8
`define SWT_OP_TEQV     4'h9
`define SWT_OP_CMP      4'hA
`define SWT_OP_CMPN     4'hB

// Program counter read offsets.
`define SWT_PC_OFS_IMM  32'h0000_0008
`define SWT_PC_OFS_REG  32'h0000_000C

// Cycle counts per instruction class.
`define SWT_FETCH_NORM  2'h1
`define SWT_FETCH_PCW   2'h3
`define SWT_FETCH_XFER  2'h1

`endif

// ---- sim/swt_exec_checker.sv ----
// Concurrent checks on the execute control block's ports.
// Assumes a single clock and the synchronous active low reset of the block.
`include "swt_regs.vh"
module swt_exec_checker (
  // Clock and reset
  input wire        clock,
  input wire        rstn,
  // Observed inputs
  input wire        regShift,
  input wire [31:0] instrAddr,
  input wire [31:0] aluResult,
  // Observed outputs
  input wire [31:0] pcOperand_q,
  input wire        pcWrite_q,
  input wire [31:0] pcValue_q,
  input wire [31:0] currentStatus_q,
  input wire [31:0] savedStatus_q,
  input wire        busy_q,
  input wire [1:0]  fetchCount_q,
  input wire        internalCycle_q,
  input wire        userPcRestore_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_busy1;
    busy_q ##1 !busy_q;
  endsequence
  sequence s_busy2;
    busy_q [*2] ##1 !busy_q;
  endsequence
  // The first edge after reset still sees the operand cleared by reset.
  AST_PC_OFS: assert property ($past(rstn) |-> pcOperand_q == $past(instrAddr) +
    ($past(regShift) ? `SWT_PC_OFS_REG : `SWT_PC_OFS_IMM)) else $error("pc operand offset");
  AST_RESV: assert property (((currentStatus_q | savedStatus_q) & ~`SWT_IMPL_MASK) == 0)
    else $error("reserved status bit set");
  AST_PCW_FETCH: assert property (pcWrite_q |-> fetchCount_q == 2'h3)
    else $error("pc write fetch count");
  AST_PCW_BUSY: assert property (pcWrite_q && !internalCycle_q |-> s_busy2)
    else $error("pc write busy length");
  AST_INT_BUSY: assert property (internalCycle_q && !pcWrite_q |-> s_busy1)
    else $error("internal cycle busy length");
  AST_PCW_VAL: assert property (pcWrite_q |-> pcValue_q == $past(aluResult))
    else $error("pc value");
  AST_ONE_FETCH: assert property (fetchCount_q == 2'h1 && !internalCycle_q |-> !busy_q)
    else $error("single fetch busy");
  AST_USR_CTL: assert property (currentStatus_q[4:0] == `SWT_MODE_USR |=>
    currentStatus_q[7:0] == $past(currentStatus_q[7:0])) else $error("user control change");
  AST_USR_PC: assert property (userPcRestore_q |-> $stable(currentStatus_q))
    else $error("user pc restore changed status");
endmodule

bind swt_exec_ctrl swt_exec_checker chk (.clock, .rstn, .regShift, .instrAddr, .aluResult,
  .pcOperand_q, .pcWrite_q, .pcValue_q, .currentStatus_q, .savedStatus_q, .busy_q,
  .fetchCount_q, .internalCycle_q, .userPcRestore_q);

// ---- sim/swt_exec_ctrl_tb_top.sv ----
// Directed testbench for the execute control block.
// Assumes the block starts in supervisor mode and the condition field uses 0xE as always.
`include "swt_regs.vh"
module swt_exec_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        issueValid = 1'b0;
  logic [3:0]  condField = 4'hE;
  logic [3:0]  opcode = 4'h0;
  logic [6:0]  ctl = 7'h00;
  logic        xferImm = 1'b0;
  logic [31:0] instrAddr = 32'h0000_0100;
  logic [31:0] xferOperand = 32'h0000_0000;
  logic [31:0] aluResult = 32'h0000_0000;
  logic [3:0]  aluFlags = 4'h0;
  wire  [31:0] pcOperand_q, pcValue_q, regWriteData_q, currentStatus_q, savedStatus_q;
  wire         pcWrite_q, regWrite_q, busy_q, internalCycle_q, userPcRestore_q;
  wire  [1:0]  fetchCount_q;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;

  swt_exec_ctrl uut (.clock, .rstn, .issueValid, .condField, .opcode, .setFlags(ctl[6]),
    .destIsPc(ctl[5]), .regShift(ctl[4]), .legacyRestore(ctl[3]), .xferIsWrite(ctl[2]),
    .xferSaved(ctl[1]), .xferFlagsOnly(ctl[0]), .xferImmediate(xferImm), .instrAddr,
    .xferOperand, .aluResult, .aluFlags, .pcOperand_q, .pcWrite_q, .pcValue_q, .regWrite_q,
    .regWriteData_q, .currentStatus_q, .savedStatus_q, .busy_q, .fetchCount_q,
    .internalCycle_q, .userPcRestore_q);

  initial forever #2 clock = ~clock;

  task test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A run still going after 3000 cycles ends here instead of running forever.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Control bits: flag-set, pc dest, reg shift, legacy, write, saved, flags only.
  task iss(input [3:0] op, input [6:0] c, input [31:0] opnd);
    int n;
    // An edge passes before the strobe rises again after the previous drop.
    @(posedge clock);
    #1 n = 0;
    while (busy_q !== 1'b0 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    if (n == 20) n_fail++;
    opcode = op;
    ctl = c;
    xferOperand = opnd;
    issueValid = 1'b1;
    @(posedge clock);
    #1 issueValid = 1'b0;
  endtask

  task t_reset;
    chk(currentStatus_q, `SWT_RESET_WORD);
    chk(savedStatus_q, 32'h0000_0000);
    @(posedge clock);
    #1 chk(savedStatus_q, `SWT_RESET_WORD);
    $display("test reset done");
  endtask

  task t_pcofs;
    instrAddr = 32'h0000_1000;
    @(posedge clock);
    #1 chk(pcOperand_q, 32'h0000_1008);
    ctl = 7'h10;
    @(posedge clock);
    #1 chk(pcOperand_q, 32'h0000_100C);
    $display("test pc operand done");
  endtask

  task t_xfer;
    iss(`SWT_OP_CMPN, 7'h06, 32'h6FFF_FF53);
    iss(`SWT_OP_TEST, 7'h02, 32'h0000_0000);
    chk(regWrite_q, 1'b1);
    chk(regWriteData_q, 32'h6000_0053);
    chk(savedStatus_q, 32'h6000_0053);
    iss(`SWT_OP_CMP, 7'h00, 32'h0000_0000);
    chk(regWriteData_q, 32'h0000_00D3);
    iss(`SWT_OP_TEQV, 7'h05, 32'h5FFF_FFFF);
    chk(currentStatus_q, 32'h5000_00D3);
    chk(fetchCount_q, 2'h1);
    chk(busy_q, 1'b0);
    condField = 4'h1;
    iss(`SWT_OP_TEQV, 7'h05, 32'hF000_0000);
    chk(currentStatus_q, 32'h5000_00D3);
    condField = 4'hE;
    xferImm = 1'b1;
    iss(`SWT_OP_TEQV, 7'h04, 32'hA000_001F);
    xferImm = 1'b0;
    chk(currentStatus_q, 32'hA000_00D3);
    $display("test transfer done");
  endtask

  task t_pcw;
    aluResult = 32'h0000_2000;
    iss(4'hD, 7'h20, 32'h0000_0000);
    chk(pcValue_q, 32'h0000_2000);
    chk(currentStatus_q, 32'hA000_00D3);
    iss(4'hD, 7'h60, 32'h0000_0000);
    chk(pcWrite_q, 1'b1);
    chk(currentStatus_q, 32'h6000_0053);
    chk(fetchCount_q, 2'h3);
    @(posedge clock);
    #1 chk(busy_q, 1'b1);
    @(posedge clock);
    #1 chk(busy_q, 1'b0);
    iss(`SWT_OP_CMPN, 7'h04, 32'h6000_0052);
    chk(currentStatus_q, 32'h6000_0052);
    iss(`SWT_OP_TEST, 7'h02, 32'h0000_0000);
    chk(regWriteData_q, `SWT_RESET_WORD);
    chk(savedStatus_q, `SWT_RESET_WORD);
    iss(`SWT_OP_CMPN, 7'h04, 32'h6000_0053);
    chk(currentStatus_q, 32'h6000_0053);
    $display("test pc write done");
  endtask

  task t_user;
    // The mode change reads the word back first so reserved bits are carried over.
    iss(`SWT_OP_CMP, 7'h00, 32'h0000_0000);
    chk(regWriteData_q, 32'h6000_0053);
    iss(`SWT_OP_CMPN, 7'h04, (regWriteData_q & 32'hFFFF_FFE0) | 32'h0000_0010);
    chk(currentStatus_q, 32'h6000_0050);
    iss(`SWT_OP_CMPN, 7'h04, 32'hF000_00D3);
    chk(currentStatus_q, 32'hF000_0050);
    chk(savedStatus_q, 32'h0000_0000);
    aluFlags = 4'h2;
    iss(`SWT_OP_CMP, 7'h50, 32'h0000_0000);
    chk(currentStatus_q, 32'h2000_0050);
    chk(regWrite_q, 1'b0);
    chk(internalCycle_q, 1'b1);
    iss(4'hD, 7'h60, 32'h0000_0000);
    chk(userPcRestore_q, 1'b1);
    chk(currentStatus_q, 32'h2000_0050);
    aluFlags = 4'h9;
    iss(`SWT_OP_TEQV, 7'h48, 32'h0000_0000);
    chk(currentStatus_q, 32'h2000_0050);
    $display("test user mode done");
  endtask

  initial begin
    repeat (10) @(posedge clock);
    #1 rstn = 1'b1;
    t_reset;
    t_pcofs;
    t_xfer;
    t_pcw;
    t_user;
    test_done;
  end
endmodule
